// ### hw/position_compare_consts.svh
`ifndef POSITION_COMPARE_CONSTS_SVH
`define POSITION_COMPARE_CONSTS_SVH

// Register indices (byte address equals index on this plain port)
`define ADDR_COMPARE_POSITION   8'h05
`define ADDR_COMPARE_REPEAT     8'h06
`define ADDR_DRIVER_CONFIG      8'h0A

// Reset values
`define RST_COMPARE_POSITION    32'hFFFFFFFF
`define RST_COMPARE_REPEAT      24'h000000
`define RST_DRIVER_CONFIG       32'h00000000

// Driver configuration fields
`define DRVCFG_RANGE_LSB        0
`define DRVCFG_RANGE_MSB        1
`define DRVCFG_SLOPE_LSB        4
`define DRVCFG_SLOPE_MSB        5

// Repeat distance above this value enables periodic mode
`define REPEAT_PERIODIC_MIN     24'h000001

`endif

// ### hw/position_compare_pkg.sv
package position_compare_pkg;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic [1:0] slope_control;
    logic [1:0] current_range;
  } driver_config_t;

  typedef enum logic [1:0] {
    RANGE_1A,
    RANGE_2A,
    RANGE_3A,
    RANGE_3A_ALT
  } current_range_t;

endpackage

// ### hw/position_compare_strobe.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`include "position_compare_consts.svh"

module position_compare_strobe #(
  parameter int POS_WIDTH    = 32,
  parameter int REPEAT_WIDTH = 24
) (
  // Clock and reset
  input  wire logic                  ref_clk_in,
  input  wire logic                  nrst_in,
  // Register port
  input  wire logic [7:0]            reg_addr_in,
  input  wire logic [31:0]           reg_wdata_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  output logic      [31:0]           reg_rdata_out,
  // Motion inputs
  input  wire logic [POS_WIDTH-1:0]  actual_position_in,
  // Strobe and stored configuration
  output logic                       diag_output_one_out,
  output logic      [1:0]            current_range_out,
  output logic      [1:0]            slope_control_out
);

  // Only the documented widths are served by the fixed slices below
  if (POS_WIDTH != 32 || REPEAT_WIDTH != 24 ||
      REPEAT_WIDTH > POS_WIDTH) begin : g_bad_width
    $error("position_compare_strobe: unsupported widths");
  end

  position_compare_pkg::reg_req_t       req;
  position_compare_pkg::driver_config_t drv_cfg_reg;
  logic [31:0] compare_position_reg;
  logic [23:0] compare_repeat_reg;
  logic [31:0] actual_prev_reg;
  logic [31:0] compare_position_next;
  logic [31:0] repeat_extended;
  logic        sel_repeat_wr;
  logic        sel_drvcfg_wr;
  logic        sel_compare_rd;
  logic        sel_repeat_rd;
  logic        sel_drvcfg_rd;
  logic        moved_up;
  logic        periodic;
  logic        match;
  logic        sw_wr_compare;

  assign req.addr  = reg_addr_in;
  assign req.wdata = reg_wdata_in;
  assign req.wr    = reg_wr_in;
  assign req.rd    = reg_rd_in;

  assign periodic      = compare_repeat_reg > `REPEAT_PERIODIC_MIN;
  assign match         = actual_position_in == compare_position_reg;
  assign moved_up      = $signed(actual_position_in - actual_prev_reg) > 0;
  assign sw_wr_compare = req.wr && req.addr == `ADDR_COMPARE_POSITION;
  assign sel_repeat_wr = req.wr && req.addr == `ADDR_COMPARE_REPEAT;
  assign sel_drvcfg_wr = req.wr && req.addr == `ADDR_DRIVER_CONFIG;

  assign sel_compare_rd  = req.rd && req.addr == `ADDR_COMPARE_POSITION;
  assign sel_repeat_rd   = req.rd && req.addr == `ADDR_COMPARE_REPEAT;
  assign sel_drvcfg_rd   = req.rd && req.addr == `ADDR_DRIVER_CONFIG;
  assign repeat_extended = {8'h00, compare_repeat_reg};

  // Previous position gives the travel direction
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      actual_prev_reg <= 32'h00000000;
    end else begin
      actual_prev_reg <= actual_position_in;
    end
  end

  // Software write wins over the hardware step of the same cycle
  always_comb begin
    compare_position_next = compare_position_reg;
    if (sw_wr_compare) begin
      compare_position_next = req.wdata;
    end else if (match && periodic) begin
      // Wraps modulo 2^32, as the position itself does
      if (moved_up) begin
        compare_position_next = compare_position_reg +
                                repeat_extended;
      end else begin
        compare_position_next = compare_position_reg -
                                repeat_extended;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      compare_position_reg <= `RST_COMPARE_POSITION;
    end else begin
      compare_position_reg <= compare_position_next;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      compare_repeat_reg <= `RST_COMPARE_REPEAT;
    end else if (req.wr && req.addr == `ADDR_COMPARE_REPEAT) begin
      compare_repeat_reg <= req.wdata[23:0];
    end
  end

  // Range is stored only; the analog effect lives elsewhere
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      drv_cfg_reg <= 4'h0;
    end else if (req.wr && req.addr == `ADDR_DRIVER_CONFIG) begin
      drv_cfg_reg.current_range <=
        req.wdata[`DRVCFG_RANGE_MSB:`DRVCFG_RANGE_LSB];
      drv_cfg_reg.slope_control <=
        req.wdata[`DRVCFG_SLOPE_MSB:`DRVCFG_SLOPE_LSB];
    end
  end

  assign current_range_out = drv_cfg_reg.current_range;
  assign slope_control_out = drv_cfg_reg.slope_control;

  // Strobe is registered, so it trails equality by one cycle
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      diag_output_one_out <= 1'b0;
    end else begin
      diag_output_one_out <= match;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (req.rd) begin
      case (req.addr)
        `ADDR_COMPARE_POSITION: reg_rdata_out <= compare_position_reg;
        `ADDR_COMPARE_REPEAT:   reg_rdata_out <= {8'h00, compare_repeat_reg};
        `ADDR_DRIVER_CONFIG: begin
          reg_rdata_out <= {26'h0000000, drv_cfg_reg.slope_control,
                            2'h0, drv_cfg_reg.current_range};
        end
        default:                reg_rdata_out <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_out <= 32'h00000000;
    end
  end

  AST_PULSE_HIGH: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    match
    |=> diag_output_one_out)
    else $error("strobe missed equality");

  AST_PULSE_LOW: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    !match
    |=> !diag_output_one_out)
    else $error("strobe high without equality");

  AST_STEP_UP: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    (match && periodic && moved_up && !sw_wr_compare) |=>
    compare_position_reg == $past(compare_position_reg) +
                            {8'h00, $past(compare_repeat_reg)})
    else $error("compare not stepped up");

  AST_STEP_DOWN: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    (match && periodic && !moved_up && !sw_wr_compare) |=>
    compare_position_reg == $past(compare_position_reg) -
                            {8'h00, $past(compare_repeat_reg)})
    else $error("compare not stepped down");

  AST_FIXED: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    (compare_repeat_reg <= 24'h000001 && !sw_wr_compare)
    |=> $stable(compare_position_reg))
    else $error("compare moved in fixed mode");

  AST_CMP_WRITE: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    sw_wr_compare ##1 (sel_compare_rd && !match)
    |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("compare readback wrong");

  AST_REP_WRITE: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    sel_repeat_wr
    |=> compare_repeat_reg == $past(reg_wdata_in[23:0]))
    else $error("repeat not written");

  AST_RANGE: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    sel_drvcfg_wr
    |=> current_range_out == $past(reg_wdata_in[1:0]))
    else $error("range not stored");

  AST_RD_IDLE: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    !reg_rd_in
    |=> reg_rdata_out == 32'h00000000)
    else $error("read data outside read slot");

  AST_RST_COMPARE: assert property (
    @(posedge ref_clk_in)
    !nrst_in
    |=> compare_position_reg == `RST_COMPARE_POSITION)
    else $error("compare reset value wrong");

  AST_RST_REPEAT: assert property (
    @(posedge ref_clk_in)
    !nrst_in
    |=> compare_repeat_reg == `RST_COMPARE_REPEAT)
    else $error("repeat reset value wrong");

  AST_RST_STROBE: assert property (
    @(posedge ref_clk_in)
    !nrst_in
    |=> !diag_output_one_out)
    else $error("strobe high in reset");

  AST_RST_RANGE: assert property (
    @(posedge ref_clk_in)
    !nrst_in
    |=> current_range_out == 2'h0)
    else $error("range reset value wrong");

  AST_RST_SLOPE: assert property (
    @(posedge ref_clk_in)
    !nrst_in
    |=> slope_control_out == 2'h0)
    else $error("slope reset value wrong");

  AST_RST_RDATA: assert property (
    @(posedge ref_clk_in)
    !nrst_in
    |=> reg_rdata_out == 32'h00000000)
    else $error("read data not cleared in reset");

  AST_CMP_READ: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    sel_compare_rd
    |=> reg_rdata_out == $past(compare_position_reg))
    else $error("compare read data wrong");

  AST_REP_READ: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    sel_repeat_rd
    |=> reg_rdata_out == {8'h00, $past(compare_repeat_reg)})
    else $error("repeat read data wrong");

  AST_CFG_READ: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    sel_drvcfg_rd
    |=> reg_rdata_out == {26'h0000000, $past(slope_control_out),
                          2'h0, $past(current_range_out)})
    else $error("configuration read data wrong");

  AST_BAD_READ: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    (reg_rd_in && !sel_compare_rd && !sel_repeat_rd && !sel_drvcfg_rd)
    |=> reg_rdata_out == 32'h00000000)
    else $error("unmapped read not zero");

  AST_SW_WINS: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    sw_wr_compare
    |=> compare_position_reg == $past(reg_wdata_in))
    else $error("compare write lost");

  AST_NO_MATCH_HOLD: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    (!match && !sw_wr_compare)
    |=> $stable(compare_position_reg))
    else $error("compare moved without match");

  AST_REP_HOLD: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    !sel_repeat_wr
    |=> $stable(compare_repeat_reg))
    else $error("repeat moved without write");

  AST_CFG_HOLD: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    !sel_drvcfg_wr
    |=> $stable(current_range_out) && $stable(slope_control_out))
    else $error("configuration moved without write");

  AST_SLOPE: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    sel_drvcfg_wr
    |=> slope_control_out == $past(reg_wdata_in[5:4]))
    else $error("slope not stored");

  AST_PERIODIC_MOVES: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    (match && periodic && !sw_wr_compare)
    |=> compare_position_reg != $past(compare_position_reg))
    else $error("periodic compare did not advance");

  AST_STROBE_PIN: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    $past(nrst_in)
    |-> diag_output_one_out == $past(match))
    else $error("pin does not carry strobe");

  AST_REF_IS_BASE: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    (match && !periodic && !sw_wr_compare)
    |=> diag_output_one_out && $stable(compare_position_reg))
    else $error("fixed reference not held");

  AST_FIXED_STAYS: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    (match && !periodic && !sw_wr_compare) ##1
    (actual_position_in == $past(actual_position_in) && !sw_wr_compare)
    |=> diag_output_one_out)
    else $error("fixed strobe dropped while still");

  AST_OTHER_WR: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    ((sel_repeat_wr || sel_drvcfg_wr) && !match)
    |=> $stable(compare_position_reg))
    else $error("compare moved on other write");

  AST_REP_NO_SIDE: assert property (
    @(posedge ref_clk_in)
    disable iff (!nrst_in)
    sw_wr_compare
    |=> $stable(compare_repeat_reg))
    else $error("repeat moved on compare write");

endmodule

// ### verification/strobe_observer.sv
`timescale 1ns/10ps
// Counts strobe pulses on the diagnostic pin, as a capture input would
module strobe_observer (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       nrst_in,
  // Observed pin
  input  wire logic       strobe_in,
  output logic      [7:0] pulses_out
);
  logic last_reg;
  always_ff @(posedge ref_clk_in) begin
    last_reg <= nrst_in & strobe_in;
    if (!nrst_in)
      pulses_out <= 8'h00;
    else if (strobe_in && !last_reg)
      pulses_out <= pulses_out + 8'h01;
  end
endmodule

// ### verification/position_compare_strobe_test.sv
`timescale 1ns/10ps
`include "position_compare_consts.svh"
module position_compare_strobe_test;
  logic        ref_clk_in, nrst_in, wr, rd, strobe;
  logic [7:0]  addr, pulses, base;
  logic [31:0] wdata, rdata, pos;
  logic [1:0]  range, slope;
  int          n_errors, n_checks;
  position_compare_strobe position_compare_strobe_inst (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .actual_position_in(pos),
    .diag_output_one_out(strobe), .current_range_out(range),
    .slope_control_out(slope));
  strobe_observer strobe_observer_inst (.ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in), .strobe_in(strobe), .pulses_out(pulses));
  task automatic check(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic check_bit(string nm, logic e, logic g);
    check(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(logic [7:0] a, logic [31:0] e);
    @(posedge ref_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    #1 check("rdata", e, rdata);
  endtask
  task automatic wr_rd(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    #1 check("rdata", d, rdata);
  endtask
  task automatic move(logic [31:0] p);
    @(posedge ref_clk_in);
    pos <= p;
  endtask
  task automatic strobe_chk(logic [31:0] p, logic e);
    move(p);
    @(posedge ref_clk_in);
    #1 check_bit("strobe", e, strobe);
  endtask
  task automatic reset_values();
    rd_chk(`ADDR_COMPARE_POSITION, 32'hFFFFFFFF);
    rd_chk(`ADDR_COMPARE_REPEAT, 32'h00000000);
    rd_chk(`ADDR_DRIVER_CONFIG, 32'h00000000);
    rd_chk(8'h07, 32'h00000000);
    strobe_chk(32'hFFFFFFFF, 1'b1);
  endtask
  task automatic fixed_compare();
    wr_reg(`ADDR_COMPARE_REPEAT, 32'hFFFFFFFF);
    rd_chk(`ADDR_COMPARE_REPEAT, 32'h00FFFFFF);
    wr_reg(`ADDR_COMPARE_REPEAT, 32'h00000001);
    wr_reg(`ADDR_COMPARE_POSITION, 32'h00000064);
    strobe_chk(32'h00000064, 1'b1);
    strobe_chk(32'h00000064, 1'b1);
    strobe_chk(32'h00000065, 1'b0);
    rd_chk(`ADDR_COMPARE_POSITION, 32'h00000064);
  endtask
  task automatic periodic();
    base = pulses;
    wr_reg(`ADDR_COMPARE_REPEAT, 32'h0000000A);
    wr_reg(`ADDR_COMPARE_POSITION, 32'h000000C8);
    for (int p = 195; p <= 215; p++) move(p);
    for (int p = 230; p >= 210; p--) move(p);
    repeat (2) @(posedge ref_clk_in);
    #1 check("pulses", 32'h4, {24'h0, pulses - base});
    rd_chk(`ADDR_COMPARE_POSITION, 32'h000000C8);
    wr_rd(`ADDR_COMPARE_POSITION, 32'h12345678);
  endtask
  task automatic driver_config();
    // Lowest fitting range first, as software should pick
    for (int i = 0; i < 4; i++) begin
      wr_reg(`ADDR_DRIVER_CONFIG, 32'(i * 17));
      rd_chk(`ADDR_DRIVER_CONFIG, 32'(i * 17));
      check("range", 32'(i), {30'h0, range});
      check("slope", 32'(i), {30'h0, slope});
    end
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    repeat (3000) @(posedge ref_clk_in);
    n_errors++;
    end_of_test();
  end
  initial begin
    {nrst_in, wr, rd, addr, wdata, pos} = '0;
    repeat (3) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    reset_values();
    fixed_compare();
    periodic();
    driver_config();
    end_of_test();
  end
endmodule
